// ==== core/urx_map.vh ====
// register offsets, field positions and encodings of the serial receive block
`ifndef URX_MAP_VH
`define URX_MAP_VH
`define URX_ADDR_W      4
`define URX_OFF_DATA    4'h0
`define URX_OFF_STAT_A  4'h4
`define URX_OFF_CTRL_B  4'h8
`define URX_OFF_CTRL_C  4'hc
`define URX_A_RXC       7
`define URX_A_FE        4
`define URX_A_DOR       3
`define URX_A_UPE       2
`define URX_B_RXCIE     7
`define URX_B_RXEN      4
`define URX_B_TRANSMIT_ENABLE_BIT      3
`define URX_B_SZ2       2
`define URX_B_RXB8      1
`define URX_B_TXB8      0
`define URX_C_SYNC      6
`define URX_C_PEN       5
`define URX_C_PODD      4
`define URX_C_STOP2     3
`define URX_C_SZ_HI     2
`define URX_C_SZ_LO     1
`define URX_SZ_NINE     3'h7
`define URX_RST_CTRL_B  8'h00
`define URX_RST_CTRL_C  8'h06
`define URX_ENT_W       12
`define URX_E_NINTH     11
`define URX_E_FE        10
`define URX_E_DOR       9
`define URX_E_UPE       8
`endif

// ==== core/urx_core.v ====
// serial receive path, receive buffer, status flags and transmit parity/disable
// Notes on behaviour
// - with parity enabled, parity bit goes between last data bit and first stop.
// - clearing transmit enable waits until shift register and buffer are empty.
// - once really disabled, transmitter releases the serial output pin.
// - receive enable hands the serial input pin to the receiver.
// - synchronous mode samples bits on the external transfer clock.
// - after start bit, shift bits up to the first stop bit; ignore second stop.
// - on first stop bit, move the frame into the receive buffer.
// - data bits above the character size read as zero.
// - nine-bit characters show their ninth bit in control register B.
// - ninth bit and error flags travel per entry; data read advances buffer.
// - receive complete is one while unread data is buffered.
// - clearing receive enable empties the buffer and clears receive complete.
// - receive complete interrupt is requested while flag and enable are set.
// - status writes cannot alter error flags; error flags raise no interrupt.
// - frame error reflects the first stop bit only.
// - overrun when buffer full, shift register waiting and a new start comes.
// - overrun pending clears when a frame moves into the buffer.
// - parity error reads zero for characters received while parity checking was disabled.
// - checker computes parity of data bits with the selected sense.
// - parity error kept per character, only if checking was on at arrival.
// - disabling the receiver is immediate and drops the frame in progress.
`timescale 1ns/1ps
`default_nettype none
`include "urx_map.vh"

module urx_core
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [31:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        serial_in_pin,
	input  wire        baud_tick,
	input  wire        external_transfer_clock,
	output wire        rx_pin_override,
	output wire        rx_complete_irq,
	input  wire        tx_shift_busy,
	input  wire        tx_buffer_full,
	output reg         tx_data_write,
	output reg  [8:0]  tx_data,
	output wire        tx_parity_bit,
	output wire        tx_parity_slot,
	output reg         tx_active,
	output wire        serial_out_override
);

	localparam ST_IDLE = 2'h0;
	localparam ST_DATA = 2'h1;
	localparam ST_PAR  = 2'h2;
	localparam ST_STOP = 2'h3;

	reg  [7:0]  ctrl_b;
	reg  [7:0]  ctrl_c;
	reg  [1:0]  state;
	reg  [3:0]  bit_cnt;
	reg  [8:0]  shift;
	reg         par_err;
	reg         par_on;
	reg         waiting;
	reg  [`URX_ENT_W-1:0] wait_ent;
	reg         ovr_pend;
	reg  [`URX_ENT_W-1:0] fifo_mem [0:1];
	reg         rd_ptr;
	reg  [1:0]  count;
	reg         xck_prev;

	wire        rx_en    = ctrl_b[`URX_B_RXEN];
	wire        par_en   = ctrl_c[`URX_C_PEN];
	wire        par_odd  = ctrl_c[`URX_C_PODD];
	wire [2:0]  char_sz  = {ctrl_b[`URX_B_SZ2], ctrl_c[`URX_C_SZ_HI:`URX_C_SZ_LO]};
	wire        nine     = (char_sz == `URX_SZ_NINE);
	wire [3:0]  n_bits   = nine ? 4'h9 : ({2'b00, char_sz[1:0]} + 4'h5);
	// a rising edge on the transfer clock replaces the baud tick
	wire        xck_rise = external_transfer_clock & ~xck_prev;
	wire        tick     = ctrl_c[`URX_C_SYNC] ? xck_rise : baud_tick;
	wire        rx_bit   = serial_in_pin;

	wire        acc      = psel & penable;
	wire [3:0]  adr      = paddr[3:0];
	wire        mapped   = (paddr[31:4] == 28'h0000000) & (adr[1:0] == 2'b00);
	wire        wr       = acc & pwrite & mapped;
	wire        rd_data  = acc & ~pwrite & mapped & (adr == `URX_OFF_DATA);

	wire        rxc      = (count != 2'h0);
	wire [`URX_ENT_W-1:0] head = fifo_mem[rd_ptr];
	wire        pop      = rd_data & rxc;
	wire        push     = waiting & ((count != 2'h2) | pop);
	wire        full     = (count == 2'h2);
	// a start is refused while both slots and the holding slot are taken
	wire        blocked  = full & waiting & ~push;
	// with both slots full, a pop in the same cycle frees the head slot, which the push refills
	wire        wr_idx   = rd_ptr ^ count[0];
	// an overrun met while this frame waited is reported with it
	wire [`URX_ENT_W-1:0] push_ent;
	assign push_ent = {wait_ent[`URX_ENT_W-1:`URX_E_DOR+1], wait_ent[`URX_E_DOR] | ovr_pend,
		wait_ent[`URX_E_DOR-1:0]};

	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	assign rx_pin_override = rx_en;
	assign rx_complete_irq = ctrl_b[`URX_B_RXCIE] & rxc;

	// parity of the outgoing character, masked to the character size
	wire [8:0]  tx_mask  = (9'h1ff >> (4'h9 - n_bits));
	urx_parity
	#(
		.WIDTH (9)
	)
	urx_parity_tx
	(
		.data   (tx_data),
		.mask   (tx_mask),
		.odd    (par_odd),
		.parity (tx_parity_bit)
	);

	assign tx_parity_slot = par_en;
	assign serial_out_override = tx_active;

	// parity of the received character, shift already holds zeros above size
	wire        calc_par;

	urx_parity
	#(
		.WIDTH (9)
	)
	urx_parity_rx
	(
		.data   (shift),
		.mask   (9'h1ff),
		.odd    (par_odd),
		.parity (calc_par)
	);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			xck_prev <= 1'b0;
		else
			xck_prev <= external_transfer_clock;
	end

	// control registers and transmit write strobe
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_b        <= `URX_RST_CTRL_B;
			ctrl_c        <= `URX_RST_CTRL_C;
			tx_data_write <= 1'b0;
			tx_data       <= 9'h000;
		end
		else
		begin
			tx_data_write <= 1'b0;
			if (wr && adr == `URX_OFF_CTRL_B)
			begin
				// received ninth bit is read only
				ctrl_b <= {pwdata[7:2], 1'b0, pwdata[0]};
			end
			if (wr && adr == `URX_OFF_CTRL_C)
				ctrl_c <= pwdata[7:0];
			if (wr && adr == `URX_OFF_DATA)
			begin
				tx_data_write <= 1'b1;
				tx_data       <= {ctrl_b[`URX_B_TXB8], pwdata[7:0]};
			end
		end
	end

	// deferred transmitter disable: enable acts at once, disable waits for drain
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tx_active <= 1'b0;
		else if (ctrl_b[`URX_B_TRANSMIT_ENABLE_BIT])
			tx_active <= 1'b1;
		else if (!tx_shift_busy && !tx_buffer_full && !tx_data_write)
			tx_active <= 1'b0;
	end

	// receive frame sequencer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state    <= ST_IDLE;
			bit_cnt  <= 4'h0;
			shift    <= 9'h000;
			par_err  <= 1'b0;
			par_on   <= 1'b0;
			waiting  <= 1'b0;
			wait_ent <= {`URX_ENT_W{1'b0}};
			ovr_pend <= 1'b0;
		end
		else if (!rx_en)
		begin
			// frame in progress is dropped, nothing survives the disable
			state    <= ST_IDLE;
			waiting  <= 1'b0;
			ovr_pend <= 1'b0;
		end
		else
		begin
			if (push)
			begin
				waiting  <= 1'b0;
				ovr_pend <= 1'b0;
			end
			if (tick)
			begin
				case (state)
				ST_IDLE:
				begin
					if (!rx_bit)
					begin
						if (blocked)
							ovr_pend <= 1'b1;
						else
						begin
							// no room is lost: a later stop re-checks the slot
							state   <= ST_DATA;
							bit_cnt <= 4'h0;
							shift   <= 9'h000;
							par_on  <= par_en;
						end
					end
				end
				ST_DATA:
				begin
					shift[bit_cnt] <= rx_bit;
					bit_cnt        <= bit_cnt + 4'h1;
					if (bit_cnt == n_bits - 4'h1)
						state <= par_on ? ST_PAR : ST_STOP;
				end
				ST_PAR:
				begin
					par_err <= par_on & (calc_par != rx_bit);
					state   <= ST_STOP;
				end
				ST_STOP:
				begin
					// only the first stop bit is looked at
					state    <= ST_IDLE;
					waiting  <= 1'b1;
					wait_ent <= {shift[8] & nine, ~rx_bit, ovr_pend | (full & waiting),
						par_on & par_err, shift[7:0]};
				end
				default:
					state <= ST_IDLE;
				endcase
			end
			if (state == ST_IDLE && tick && !rx_bit && !blocked)
				par_err <= 1'b0;
		end
	end

	// two-entry receive buffer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rd_ptr      <= 1'b0;
			count       <= 2'h0;
			fifo_mem[0] <= {`URX_ENT_W{1'b0}};
			fifo_mem[1] <= {`URX_ENT_W{1'b0}};
		end
		else if (!rx_en)
		begin
			rd_ptr <= 1'b0;
			count  <= 2'h0;
		end
		else
		begin
			if (push)
				fifo_mem[wr_idx] <= push_ent;
			if (pop)
				rd_ptr <= ~rd_ptr;
			if (push && !pop)
				count <= count + 2'h1;
			else if (pop && !push)
				count <= count - 2'h1;
		end
	end

	// read mux; error flag bits come from the buffer head only
	always @*
	begin
		prdata = 32'h00000000;
		if (acc && !pwrite && mapped)
		begin
			case (adr)
			`URX_OFF_DATA:
				prdata[7:0] = rxc ? head[7:0] : 8'h00;
			`URX_OFF_STAT_A:
			begin
				prdata[`URX_A_RXC] = rxc;
				prdata[`URX_A_FE]  = rxc & head[`URX_E_FE];
				prdata[`URX_A_DOR] = rxc & head[`URX_E_DOR];
				prdata[`URX_A_UPE] = rxc & head[`URX_E_UPE];
			end
			`URX_OFF_CTRL_B:
			begin
				prdata[7:0]         = ctrl_b;
				prdata[`URX_B_RXB8] = rxc & head[`URX_E_NINTH];
			end
			`URX_OFF_CTRL_C:
				prdata[7:0] = ctrl_c;
			default:
				prdata = 32'h00000000;
			endcase
		end
	end

endmodule

// parity over the masked bits of a character, even or odd sense
module urx_parity
#(
	parameter WIDTH = 9
)
(
	input  wire [WIDTH-1:0] data,
	input  wire [WIDTH-1:0] mask,
	input  wire             odd,
	output wire             parity
);

	// a set odd select inverts the even result
	assign parity = (^(data & mask)) ^ odd;

endmodule

`default_nettype wire

// ==== bench/urx_assertions.sv ====
// checker for the serial receive block ports
`timescale 1ns/1ps
`default_nettype none
module urx_assertions
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        rx_pin_override,
	input wire logic        rx_complete_irq,
	input wire logic        tx_shift_busy,
	input wire logic        tx_buffer_full,
	input wire logic        tx_active,
	input wire logic        tx_parity_slot,
	input wire logic        serial_out_override
);
	wire acc = psel && penable;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	rx_pin_a: assert property (acc && pwrite && paddr == 8 |=>
		rx_pin_override == $past(pwdata[4])) else $error("rx pin ownership wrong");
	rx_flush_a: assert property (acc && pwrite && paddr == 8 && !pwdata[4] |->
		##2 !rx_complete_irq) else $error("buffer not flushed");
	tx_on_a: assert property (acc && pwrite && paddr == 8 && pwdata[3] |->
		##2 tx_active) else $error("transmitter not enabled");
	tx_hold_a: assert property (tx_active && (tx_shift_busy || tx_buffer_full) |=>
		tx_active) else $error("transmitter stopped early");
	tx_pin_a: assert property (serial_out_override == tx_active)
		else $error("output pin ownership wrong");
	par_slot_a: assert property (acc && pwrite && paddr == 12 |=>
		tx_parity_slot == $past(pwdata[5])) else $error("parity slot wrong");
	irq_rxc_a: assert property (acc && !pwrite && paddr == 4 && rx_complete_irq |->
		prdata[7]) else $error("irq without receive complete");
	rd_high_a: assert property (acc && !pwrite && paddr == 0 |->
		prdata[31:8] == 0) else $error("upper data bits set");
	bad_addr_a: assert property (acc && paddr >= 16 |-> pslverr && prdata == 0)
		else $error("unmapped access not refused");
endmodule
bind urx_core urx_assertions urx_assertions_inst (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pslverr, .rx_pin_override, .rx_complete_irq, .tx_shift_busy,
	.tx_buffer_full, .tx_active, .tx_parity_slot, .serial_out_override);
`default_nettype wire

// ==== bench/urx_remote_tx.sv ====
// remote serial transmitter model on the receive line
`timescale 1ns/1ps
`default_nettype none
module urx_remote_tx
(
	input  wire logic        pclk,
	input  wire logic        tick,
	input  wire logic        go,
	input  wire logic [12:0] bits,
	input  wire logic [3:0]  len,
	output var  logic        line,
	output var  logic        busy
);
	logic [12:0] sh = 0;
	logic [3:0]  cnt = 0;
	initial line = 1;
	initial busy = 0;
	// frame ends in a high bit, so the line rests at idle
	always @(posedge pclk)
		if (go)
		begin
			sh <= bits;
			cnt <= len;
			busy <= 1;
		end
		else if (busy && tick)
		begin
			line <= sh[0];
			sh <= sh >> 1;
			cnt <= cnt - 1;
			busy <= cnt != 1;
		end
endmodule
`default_nettype wire

// ==== bench/uart_receiver_and_tx_parity_tb_top.sv ====
// bench top: receive block against a frame model
`timescale 1ns/1ps
`default_nettype none
module uart_receiver_and_tx_parity_tb_top;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [31:0] paddr = 0, pwdata = 0, prdata, r;
	logic        pready, pslverr, line, go = 0, busy, txb = 0, txf = 0, txa, twr, tpar;
	logic [8:0]  tdat;
	logic [12:0] v = 0;
	logic [3:0]  len = 0;
	logic [2:0]  tc = 0;
	integer      mismatches = 0, num_checks = 0, seed = 32'h494f9508;
	integer      i, k, n, z, c, d, pen, odd, bad, fe, sync = 0, q[$];
	always #50 pclk = ~pclk;
	always @(posedge pclk) tc <= tc + 1;
	urx_core urx_core_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .serial_in_pin(line), .baud_tick(tc[1:0] == 2'h0),
		.external_transfer_clock(tc[2]), .rx_pin_override(), .rx_complete_irq(),
		.tx_shift_busy(txb), .tx_buffer_full(txf), .tx_data_write(twr), .tx_data(tdat),
		.tx_parity_bit(tpar), .tx_parity_slot(), .tx_active(txa), .serial_out_override());
	// in synchronous mode the line moves once per transfer clock, half the baud rate
	urx_remote_tx urx_remote_tx_inst (.pclk, .tick(sync ? tc == 3'h4 : tc[1:0] == 2'h0),
		.go, .bits(v), .len, .line, .busy);
	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] o);
		num_checks++;
		if (o !== e)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", s, e, o);
		end
	endtask
	// read data is taken at the edge that samples pready, before the pop lands
	task apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		{psel, penable} <= 2'b00;
	endtask
	task send;
		logic [12:0] f;
		f = 0;
		for (i = 0; i < n; i++) f[i+1] = d[i];
		k = n + 1;
		if (pen)
			f[k++] = ^(d & ((1 << n) - 1)) ^ odd ^ bad;
		f[k] = !fe;
		f[k+1] = 1;
		{v, len, go} <= {f, 4'(k + 2), 1'b1};
		@(posedge pclk);
		go <= 0;
		@(posedge pclk);
		while (busy) @(posedge pclk);
	endtask
	task poll;
		k = 0;
		do apb(0, 4, 0); while (r[7] !== 1'b1 && ++k < 20);
	endtask
	initial
	begin
		#2000000;
		mismatches++;
		complete_run;
	end
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1;
		for (z = 0; z < 25; z++)
		begin
			c = z % 5 == 4 ? 7 : z % 5;
			n = c == 7 ? 9 : c + 5;
			d = $random(seed) & 511;
			pen = $random(seed) & 1;
			odd = $random(seed) & 1;
			bad = pen & $random(seed);
			fe = ($random(seed) & 3) == 0;
			sync = (z / 5) & 1;
			apb(1, 12, sync << 6 | pen << 5 | odd << 4 | (c & 3) << 1);
			apb(1, 8, 32'h90 | (c & 4));
			send;
			poll;
			chk("status", 128 | fe << 4 | bad << 2, r);
			apb(1, 4, 0);
			apb(0, 4, 0);
			chk("status kept", 128 | fe << 4 | bad << 2, r);
			apb(0, 8, 0);
			chk("ctrl_b", 32'h90 | (c & 4) | (n == 9 && d[8]) << 1, r);
			apb(0, 0, 0);
			chk("data", d & 255 & ((1 << n) - 1), r);
			apb(0, 4, 0);
			chk("empty", 0, r);
		end
		$display("test frames done");
		{pen, bad, fe, n} = {32'd0, 32'd0, 32'd0, 32'd8};
		sync = 0;
		apb(1, 12, 6);
		for (z = 0; z < 4; z++)
		begin
			d = $random(seed) & 255;
			q.push_back(d);
			send;
		end
		for (z = 0; z < 3; z++)
		begin
			poll;
			chk("ovr status", 128 | (z == 2) << 3, r);
			apb(0, 0, 0);
			chk("ovr data", q[z], r);
		end
		apb(0, 4, 0);
		chk("ovr empty", 0, r);
		$display("test overrun done");
		send;
		apb(1, 8, 32'h80);
		apb(1, 4, 0);
		apb(0, 4, 0);
		chk("flushed", 0, r);
		$display("test flush done");
		for (z = 0; z < 4; z++)
		begin
			c = z == 3 ? 7 : z;
			n = c == 7 ? 9 : c + 5;
			d = $random(seed) & 511;
			odd = $random(seed) & 1;
			apb(1, 12, 32'h20 | odd << 4 | (c & 3) << 1);
			apb(1, 8, (c & 4) | d[8]);
			apb(1, 0, d & 255);
			@(posedge pclk);
			chk("tx strobe", 1, twr);
			chk("tx data", d, tdat);
			chk("tx parity", ^(d & ((1 << n) - 1)) ^ odd, tpar);
		end
		$display("test transmit parity done");
		apb(1, 8, 8);
		{txb, txf} <= 2'b10;
		apb(1, 8, 0);
		chk("tx busy", 1, txa);
		{txb, txf} <= 2'b01;
		repeat (3) @(posedge pclk);
		chk("tx full", 1, txa);
		txf <= 0;
		repeat (3) @(posedge pclk);
		chk("tx off", 0, txa);
		$display("test transmit disable done");
		apb(0, 32'h10, 0);
		chk("unmapped", 0, r);
		$display("test unmapped done");
		complete_run;
	end
endmodule
`default_nettype wire
